/* logic/ieprc_top.sv */
// How it works
// - Enable 1 lets a pending request through; 0 blocks it while its flag stays set.
// - Each source has a flag that goes to 1 when its request occurs and reads 0 until then.
// - Each source has a 3-bit priority: 111 is the highest, level 7, and 001 is level 1.
// - A priority of 000 keeps its source from the CPU, whatever the enable bit holds; its flag and irq_out still follow its events.
// - Unimplemented bits of the enable and priority registers read as zero and ignore writes.
// - After reset all enable bits are 0 and every priority field is 100, level 4.
// - Second enable register: conv pair b 15, conv pair a 14, comparator b 7, pwm gen d 1.
// - Third enable register: conversion pair g at bit 4, pair d at bit 1, pair c at bit 0.
// - Priority register 0: timer a 14-12, compare out 10-8, capture in 6-4, ext irq a 2-0.
// - Priority register 1 holds only timer b at 14-12.
// - Priority register 2: serial rx 14-12, sync serial event 10-8, sync serial error 6-4.
//
// Added by the designer: register access over AHB-Lite and the register addresses.
module ieprc_top
    import ieprc_pkg::*;
#(
    parameter logic [NUM_SRC-1:0] SRC_PRESENT = 18'h3_FFFF
)
(
    input  wire logic                          clk_sys,
    input  wire logic                          srst,
    input  wire logic                          hsel,
    input  wire logic [31:0]                   haddr,
    input  wire logic [1:0]                    htrans,
    input  wire logic                          hwrite,
    input  wire logic [2:0]                    hsize,
    input  wire logic [31:0]                   hwdata,
    input  wire logic                          hready,
    output logic      [31:0]                   hrdata,
    output logic                               hreadyout,
    output logic                               hresp,
    input  wire logic [NUM_SRC-1:0]            src_event,
    input  wire logic [NUM_PR_SRC-1:0]         ext_enable,
    input  wire logic [NUM_EN_SRC-1:0][PRIO_W-1:0] ext_prio,
    input  wire logic                          cpu_ack,
    input  wire logic [SRC_IDX_W-1:0]          cpu_ack_src,
    output logic      [NUM_SRC-1:0]            req_pending,
    output logic      [NUM_SRC-1:0][PRIO_W-1:0] req_prio,
    output logic                               cpu_req,
    output logic      [PRIO_W-1:0]             cpu_req_prio,
    output logic      [SRC_IDX_W-1:0]          cpu_req_src,
    output logic                               irq_out
);

    ieprc_reg_if rif ();

    logic [REG_W-1:0]   en_reg [NUM_REGS];
    logic [REG_W-1:0]   pr_reg [NUM_REGS];
    logic [NUM_SRC-1:0] flag_reg;
    logic [NUM_SRC-1:0] flag_next;
    logic [NUM_SRC-1:0] mask_reg;
    logic [NUM_SRC-1:0] src_en;
    logic [NUM_SRC-1:0] fwd;
    ieprc_prio_t        src_pr [NUM_SRC];

    function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] off);
        return a == off;
    endfunction

    // Writable bits of an enable register for the sources this build holds.
    function automatic logic [REG_W-1:0] en_mask(input int r);
        logic [REG_W-1:0] m;
        m = '0;
        for (int i = 0; i < NUM_EN_SRC; i++) begin
            if (EN_REG[i] == r && SRC_PRESENT[i]) begin
                m[EN_BIT[i]] = 1'b1;
            end
        end
        return m;
    endfunction

    function automatic logic [REG_W-1:0] pr_mask(input int r);
        logic [REG_W-1:0] m;
        m = '0;
        for (int j = 0; j < NUM_PR_SRC; j++) begin
            if (PR_REG[j] == r && SRC_PRESENT[NUM_EN_SRC+j]) begin
                m[PR_LSB[j] +: PRIO_W] = '1;
            end
        end
        return m;
    endfunction

    function automatic logic [REG_W-1:0] pr_rst(input int r);
        logic [REG_W-1:0] v;
        v = '0;
        for (int j = 0; j < NUM_PR_SRC; j++) begin
            if (PR_REG[j] == r && SRC_PRESENT[NUM_EN_SRC+j]) begin
                v[PR_LSB[j] +: PRIO_W] = PRIO_FIELD_RST;
            end
        end
        return v;
    endfunction

    ieprc_ahb_port u_port (
        .clk_sys   (clk_sys),
        .srst      (srst),
        .hsel      (hsel),
        .haddr     (haddr),
        .htrans    (htrans),
        .hwrite    (hwrite),
        .hsize     (hsize),
        .hwdata    (hwdata),
        .hready    (hready),
        .hrdata    (hrdata),
        .hreadyout (hreadyout),
        .hresp     (hresp),
        .rif       (rif.bus)
    );

    // Only bits named in the field tables are stored, so the rest read as zero.
    // en_reg[0..2] are irq_enable_pwm_jtag, irq_enable_adc_pair_cmp and
    // irq_enable_adc_pair_upper; pr_reg[0..2] are irq_priority_timer_capture,
    // irq_priority_timer2 and irq_priority_serial.
    for (genvar r = 0; r < NUM_REGS; r++) begin : g_regs
        always_ff @(posedge clk_sys) begin
            if (srst) begin
                en_reg[r] <= EN_RST_VAL;
            end else if (rif.wr_stb && hit(rif.addr, OFF_EN[r])) begin
                en_reg[r] <= rif.wdata[REG_W-1:0] & en_mask(r);
            end
        end

        always_ff @(posedge clk_sys) begin
            if (srst) begin
                pr_reg[r] <= pr_rst(r);
            end else if (rif.wr_stb && hit(rif.addr, OFF_PR[r])) begin
                pr_reg[r] <= rif.wdata[REG_W-1:0] & pr_mask(r);
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            mask_reg <= MASK_RST_VAL;
        end else if (rif.wr_stb && hit(rif.addr, OFF_FLAG_MASK)) begin
            mask_reg <= rif.wdata[NUM_SRC-1:0] & SRC_PRESENT;
        end
    end

    // Hiding a field here is not enough: the register itself never holds it.
    for (genvar i = 0; i < NUM_EN_SRC; i++) begin : g_en_src
        assign src_en[i] = en_reg[EN_REG[i]][EN_BIT[i]];
        assign src_pr[i] = ext_prio[i];
    end

    for (genvar j = 0; j < NUM_PR_SRC; j++) begin : g_pr_src
        assign src_en[NUM_EN_SRC+j] = ext_enable[j];
        assign src_pr[NUM_EN_SRC+j] = pr_reg[PR_REG[j]][PR_LSB[j] +: PRIO_W];
    end

    // An event landing on the same edge as a clear wins over the clear.
    always_comb begin
        flag_next = flag_reg;
        if (rif.rd_stb && hit(rif.addr, OFF_FLAG_STATUS)) begin
            flag_next = '0;
        end
        if (cpu_ack && cpu_ack_src < SRC_IDX_W'(NUM_SRC)) begin
            flag_next[cpu_ack_src] = 1'b0;
        end
        flag_next = flag_next | (src_event & SRC_PRESENT);
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            flag_reg <= FLAG_RST_VAL;
        end else begin
            flag_reg <= flag_next;
        end
    end

    // A blocked source keeps its flag; it is only kept from the CPU.
    for (genvar k = 0; k < NUM_SRC; k++) begin : g_fwd
        assign fwd[k] = flag_reg[k] && src_en[k] && SRC_PRESENT[k]
                        && (src_pr[k] != PRIO_DISABLED);
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            req_pending <= '0;
        end else begin
            req_pending <= fwd;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            req_prio <= '0;
        end else begin
            for (int k = 0; k < NUM_SRC; k++) begin
                req_prio[k] <= fwd[k] ? src_pr[k] : PRIO_DISABLED;
            end
        end
    end

    ieprc_arbiter u_arb (
        .clk_sys   (clk_sys),
        .srst      (srst),
        .req       (fwd),
        .prio      (src_pr),
        .win_valid (cpu_req),
        .win_prio  (cpu_req_prio),
        .win_src   (cpu_req_src)
    );

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            irq_out <= 1'b0;
        end else begin
            irq_out <= |(flag_next & mask_reg);
        end
    end

    always_comb begin
        rif.rdata = '0;
        for (int r = 0; r < NUM_REGS; r++) begin
            if (hit(rif.addr, OFF_EN[r])) begin
                rif.rdata = {16'h0000, en_reg[r]};
            end
            if (hit(rif.addr, OFF_PR[r])) begin
                rif.rdata = {16'h0000, pr_reg[r]};
            end
        end
        if (hit(rif.addr, OFF_FLAG_STATUS)) begin
            rif.rdata = {14'h0000, flag_reg};
        end
        if (hit(rif.addr, OFF_FLAG_MASK)) begin
            rif.rdata = {14'h0000, mask_reg};
        end
    end

endmodule

/* logic/ieprc_pkg.sv */
package ieprc_pkg;

    localparam int NUM_SRC    = 18;
    localparam int NUM_EN_SRC = 10;
    localparam int NUM_PR_SRC = 8;
    localparam int NUM_REGS   = 3;
    localparam int PRIO_W     = 3;
    localparam int REG_W      = 16;
    localparam int ADDR_W     = 8;
    localparam int SRC_IDX_W  = 5;

    localparam logic [ADDR_W-1:0] OFF_EN [NUM_REGS] = '{8'h00, 8'h04, 8'h08};
    localparam logic [ADDR_W-1:0] OFF_PR [NUM_REGS] = '{8'h0C, 8'h10, 8'h14};
    localparam logic [ADDR_W-1:0] OFF_FLAG_STATUS   = 8'h18;
    localparam logic [ADDR_W-1:0] OFF_FLAG_MASK     = 8'h1C;

    localparam logic [REG_W-1:0]   EN_RST_VAL     = 16'h0000;
    localparam logic [PRIO_W-1:0]  PRIO_FIELD_RST = 3'b100;
    localparam logic [PRIO_W-1:0]  PRIO_DISABLED  = 3'b000;
    localparam logic [NUM_SRC-1:0] FLAG_RST_VAL   = 18'h0_0000;
    localparam logic [NUM_SRC-1:0] MASK_RST_VAL   = 18'h0_0000;

    // Sources 0..9 own an enable bit here; sources 10..17 own a priority field here.
    // Order: pwm_b, pwm_a, scan_port, conv_b, conv_a, comparator_b, pwm_d,
    // conv_g, conv_d, conv_c, then timer_a, compare_out, capture_in, ext_irq_a,
    // timer_b, serial_rx, sync_serial_event, sync_serial_error.
    localparam int EN_REG [NUM_EN_SRC] = '{0, 0, 0, 1, 1, 1, 1, 2, 2, 2};
    localparam int EN_BIT [NUM_EN_SRC] = '{15, 14, 0, 15, 14, 7, 1, 4, 1, 0};
    localparam int PR_REG [NUM_PR_SRC] = '{0, 0, 0, 0, 1, 2, 2, 2};
    localparam int PR_LSB [NUM_PR_SRC] = '{12, 8, 4, 0, 12, 12, 8, 4};

    localparam logic [2:0] HSIZE_WORD = 3'b010;

    typedef enum logic [2:0] {
        BUS_IDLE  = 3'b001,
        BUS_WRITE = 3'b010,
        BUS_READ  = 3'b100
    } ieprc_bus_state_t;

    typedef logic [PRIO_W-1:0] ieprc_prio_t;

endpackage

/* logic/ieprc_reg_if.sv */
interface ieprc_reg_if;
    import ieprc_pkg::*;

    logic              wr_stb;
    logic              rd_stb;
    logic [ADDR_W-1:0] addr;
    logic [31:0]       wdata;
    logic [31:0]       rdata;

    modport bus  (output wr_stb, output rd_stb, output addr, output wdata, input rdata);
    modport regs (input wr_stb, input rd_stb, input addr, input wdata, output rdata);
endinterface

/* logic/ieprc_ahb_port.sv */
module ieprc_ahb_port
    import ieprc_pkg::*;
(
    input  wire logic        clk_sys,
    input  wire logic        srst,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    ieprc_reg_if.bus         rif
);

    ieprc_bus_state_t  state_reg;
    logic [ADDR_W-1:0] addr_reg;
    logic              word_reg;
    logic              take;

    assign take = hsel && hready && htrans[1] && hreadyout;

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            state_reg <= BUS_IDLE;
        end else begin
            unique case (state_reg)
                BUS_IDLE, BUS_WRITE: begin
                    if (take) begin
                        state_reg <= hwrite ? BUS_WRITE : BUS_READ;
                    end else begin
                        state_reg <= BUS_IDLE;
                    end
                end
                BUS_READ: state_reg <= BUS_IDLE;
                default:  state_reg <= BUS_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            addr_reg <= '0;
            word_reg <= 1'b0;
        end else if (take) begin
            addr_reg <= haddr[ADDR_W-1:0];
            word_reg <= (hsize == HSIZE_WORD) && (haddr[1:0] == 2'b00);
        end
    end

    // A read inserts one wait state so that hrdata comes from a flip-flop.
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            hreadyout <= 1'b1;
            hrdata    <= '0;
            hresp     <= 1'b0;
        end else begin
            hresp <= 1'b0;
            if (take && !hwrite) begin
                hreadyout <= 1'b0;
            end else if (state_reg == BUS_READ) begin
                hreadyout <= 1'b1;
                hrdata    <= rif.rdata;
            end
        end
    end

    assign rif.wr_stb = (state_reg == BUS_WRITE) && word_reg;
    assign rif.rd_stb = (state_reg == BUS_READ);
    assign rif.addr   = addr_reg;
    assign rif.wdata  = hwdata;

endmodule

/* logic/ieprc_arbiter.sv */
module ieprc_arbiter
    import ieprc_pkg::*;
(
    input  wire logic                   clk_sys,
    input  wire logic                   srst,
    input  wire logic [NUM_SRC-1:0]     req,
    input  wire ieprc_prio_t            prio [NUM_SRC],
    output logic                        win_valid,
    output ieprc_prio_t                 win_prio,
    output logic      [SRC_IDX_W-1:0]   win_src
);

    logic                 best_valid;
    ieprc_prio_t          best_prio;
    logic [SRC_IDX_W-1:0] best_src;

    // Highest priority wins; among equals the lowest source index wins.
    always_comb begin
        best_valid = 1'b0;
        best_prio  = PRIO_DISABLED;
        best_src   = '0;
        for (int i = 0; i < NUM_SRC; i++) begin
            if (req[i] && (!best_valid || prio[i] > best_prio)) begin
                best_valid = 1'b1;
                best_prio  = prio[i];
                best_src   = SRC_IDX_W'(i);
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            win_valid <= 1'b0;
            win_prio  <= PRIO_DISABLED;
            win_src   <= '0;
        end else begin
            win_valid <= best_valid;
            win_prio  <= best_prio;
            win_src   <= best_src;
        end
    end

endmodule

/* verif/ieprc_props.sv */
module ieprc_props
    import ieprc_pkg::*;
(
    input wire logic                           clk_sys,
    input wire logic                           srst,
    input wire logic                           hsel,
    input wire logic [1:0]                     htrans,
    input wire logic                           hwrite,
    input wire logic                           hready,
    input wire logic [31:0]                    hrdata,
    input wire logic                           hreadyout,
    input wire logic                           hresp,
    input wire logic [NUM_SRC-1:0]             src_event,
    input wire logic                           cpu_ack,
    input wire logic [SRC_IDX_W-1:0]           cpu_ack_src,
    input wire logic [NUM_SRC-1:0]             req_pending,
    input wire logic [NUM_SRC-1:0][PRIO_W-1:0] req_prio,
    input wire logic                           cpu_req,
    input wire logic [PRIO_W-1:0]              cpu_req_prio,
    input wire logic [SRC_IDX_W-1:0]           cpu_req_src,
    input wire logic                           irq_out
);
    logic [NUM_SRC-1:0] nz;
    ieprc_prio_t        maxp;
    logic               taken;

    assign taken = hsel && hready && htrans[1] && hreadyout;

    // Highest priority among the forwarded sources.
    always_comb begin
        maxp = '0;
        for (int i = 0; i < NUM_SRC; i++) begin
            nz[i] = |req_prio[i];
            if (req_pending[i] && req_prio[i] > maxp) begin
                maxp = req_prio[i];
            end
        end
    end

    a_prio_marks_req: assert property (@(posedge clk_sys) disable iff (srst)
        nz == req_pending) else $error("request and priority outputs disagree");
    a_cpu_req_any: assert property (@(posedge clk_sys) disable iff (srst)
        cpu_req == (|req_pending)) else $error("cpu request without pending source");
    a_winner_top: assert property (@(posedge clk_sys) disable iff (srst)
        cpu_req |-> req_pending[cpu_req_src] && cpu_req_prio == maxp
        && req_prio[cpu_req_src] == maxp) else $error("winner is not the highest priority");
    a_ack_clears: assert property (@(posedge clk_sys) disable iff (srst)
        (cpu_ack && cpu_ack_src < NUM_SRC && !src_event[cpu_ack_src])
        ##1 !src_event[$past(cpu_ack_src)] |=> !req_pending[$past(cpu_ack_src, 2)])
        else $error("acknowledged source still pending");
    a_read_wait: assert property (@(posedge clk_sys) disable iff (srst)
        taken && !hwrite |=> !hreadyout ##1 hreadyout) else $error("read wait not one cycle");
    a_write_ready: assert property (@(posedge clk_sys) disable iff (srst)
        taken && hwrite |=> hreadyout) else $error("write inserted a wait");
    a_resp_okay: assert property (@(posedge clk_sys) disable iff (srst)
        hresp == 1'b0) else $error("response not OKAY");
    a_reset_clear: assert property (@(posedge clk_sys)
        srst |=> !irq_out && !cpu_req && req_pending == '0 && hrdata == '0)
        else $error("outputs not cleared by reset");
endmodule

bind ieprc_top ieprc_props ieprc_props_inst (
    .clk_sys(clk_sys), .srst(srst), .hsel(hsel), .htrans(htrans), .hwrite(hwrite),
    .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .src_event(src_event), .cpu_ack(cpu_ack), .cpu_ack_src(cpu_ack_src),
    .req_pending(req_pending), .req_prio(req_prio), .cpu_req(cpu_req),
    .cpu_req_prio(cpu_req_prio), .cpu_req_src(cpu_req_src), .irq_out(irq_out)
);

/* verif/ieprc_cpu_model.sv */
module ieprc_cpu_model
    import ieprc_pkg::*;
(
    input  wire logic                 clk_sys,
    input  wire logic                 ack_en,
    input  wire logic [3:0]           ack_lat,
    input  wire logic                 cpu_req,
    input  wire logic [SRC_IDX_W-1:0] cpu_req_src,
    output logic                      cpu_ack,
    output logic      [SRC_IDX_W-1:0] cpu_ack_src
);
    timeunit 1ns;
    timeprecision 1ns;

    // Takes the winning request after ack_lat cycles, then lets it drain.
    initial begin
        cpu_ack = 1'b0;
        cpu_ack_src = '0;
        forever begin
            @(posedge clk_sys);
            if (ack_en && cpu_req === 1'b1) begin
                repeat (ack_lat) @(posedge clk_sys);
                cpu_ack <= 1'b1;
                cpu_ack_src <= cpu_req_src;
                @(posedge clk_sys);
                cpu_ack <= 1'b0;
                repeat (3) @(posedge clk_sys);
            end
        end
    end
endmodule

/* verif/test_interrupt_enable_priority_regs.sv */
module test_interrupt_enable_priority_regs
    import ieprc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;

    localparam logic [31:0] reset_vals [6] = '{32'h0000_0000, 32'h0000_0000, 32'h0000_0000,
        32'h0000_4444, 32'h0000_4000, 32'h0000_4440};
    localparam logic [31:0] impl_masks [6] = '{32'h0000_C001, 32'h0000_C082, 32'h0000_0013,
        32'h0000_7777, 32'h0000_7000, 32'h0000_7770};

    logic                              clk_sys = 1'b0;
    logic                              srst = 1'b1;
    logic [31:0]                       haddr = '0;
    logic [31:0]                       hwdata = '0;
    logic [1:0]                        htrans = 2'b00;
    logic                              hwrite = 1'b0;
    logic [NUM_SRC-1:0]                src_event = '0;
    logic [NUM_PR_SRC-1:0]             ext_enable = '0;
    logic [NUM_EN_SRC-1:0][PRIO_W-1:0] ext_prio = '0;
    logic                              ack_en = 1'b0;
    logic [3:0]                        ack_lat = 4'h0;
    logic [31:0]                       hrdata, rd;
    logic [31:0]                       part_hrdata;
    logic                              hreadyout, hresp, cpu_ack, cpu_req, irq_out;
    logic [NUM_SRC-1:0]                req_pending;
    logic [NUM_SRC-1:0][PRIO_W-1:0]    req_prio;
    logic [PRIO_W-1:0]                 cpu_req_prio;
    logic [SRC_IDX_W-1:0]              cpu_req_src, cpu_ack_src;
    int                                bad_count = 0;
    int                                num_checks = 0;

    ieprc_top ieprc_top_inst (
        .clk_sys(clk_sys), .srst(srst), .hsel(1'b1), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(HSIZE_WORD), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .src_event(src_event),
        .ext_enable(ext_enable), .ext_prio(ext_prio), .cpu_ack(cpu_ack),
        .cpu_ack_src(cpu_ack_src), .req_pending(req_pending), .req_prio(req_prio),
        .cpu_req(cpu_req), .cpu_req_prio(cpu_req_prio), .cpu_req_src(cpu_req_src),
        .irq_out(irq_out)
    );

    // A build without pwm generator b shares the bus; its bit must stay zero.
    ieprc_top #(
        .SRC_PRESENT(18'h3_FFFE)
    ) ieprc_top_part_inst (
        .clk_sys(clk_sys), .srst(srst), .hsel(1'b1), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(HSIZE_WORD), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(part_hrdata), .hreadyout(), .hresp(), .src_event(src_event),
        .ext_enable(ext_enable), .ext_prio(ext_prio), .cpu_ack(1'b0),
        .cpu_ack_src(5'h00), .req_pending(), .req_prio(), .cpu_req(), .cpu_req_prio(),
        .cpu_req_src(), .irq_out()
    );

    ieprc_cpu_model ieprc_cpu_model_inst (
        .clk_sys(clk_sys), .ack_en(ack_en), .ack_lat(ack_lat), .cpu_req(cpu_req),
        .cpu_req_src(cpu_req_src), .cpu_ack(cpu_ack), .cpu_ack_src(cpu_ack_src)
    );

    initial begin
        forever #50 clk_sys = ~clk_sys;
    end

    task print_verdict;
        if (bad_count == 0 && num_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
            bad_count++;
        end
    endtask

    task wait_rdy;
        int n;
        n = 0;
        do begin
            @(posedge clk_sys);
            n++;
        end while (hreadyout !== 1'b1 && n < 20);
        if (hreadyout !== 1'b1) begin
            bad_count++;
            print_verdict;
        end
    endtask

    task ahb_wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
        htrans <= 2'b10;
        haddr <= 32'(a);
        hwrite <= 1'b1;
        wait_rdy;
        htrans <= 2'b00;
        hwdata <= d;
        wait_rdy;
    endtask

    task ahb_rd(input logic [ADDR_W-1:0] a, output logic [31:0] d);
        htrans <= 2'b10;
        haddr <= 32'(a);
        hwrite <= 1'b0;
        wait_rdy;
        htrans <= 2'b00;
        wait_rdy;
        d = hrdata;
    endtask

    // One-cycle event, then time for the request outputs to follow.
    task pulse(input int i);
        src_event[i] <= 1'b1;
        @(posedge clk_sys);
        src_event[i] <= 1'b0;
        repeat (2) @(posedge clk_sys);
    endtask

    task t_regs;
        logic [ADDR_W-1:0] a;
        for (int i = 0; i < 6; i++) begin
            a = (i < 3) ? OFF_EN[i] : OFF_PR[i-3];
            ahb_rd(a, rd);
            chk(rd, reset_vals[i]);
            ahb_wr(a, 32'hFFFF_FFFF);
            ahb_rd(a, rd);
            chk(rd, impl_masks[i]);
            if (i == 0) chk(part_hrdata, 32'h0000_4001);
            ahb_wr(a, 32'h0000_0000);
            ahb_rd(a, rd);
            chk(rd, 32'h0000_0000);
        end
        ahb_rd(OFF_FLAG_MASK, rd);
        chk(rd, 32'h0000_0000);
        ahb_rd(8'h40, rd);
        chk(rd, 32'h0000_0000);
    endtask

    task t_forward;
        ext_prio[0] <= 3'h3;
        ext_enable <= 8'h03;
        ahb_wr(OFF_PR[0], 32'h0000_7000);
        pulse(0);
        chk(req_pending, 32'h0000_0000);
        pulse(11);
        chk(req_pending, 32'h0000_0000);
        ahb_rd(OFF_FLAG_STATUS, rd);
        chk(rd, 32'h0000_0801);
        chk(part_hrdata, 32'h0000_0800);
        ahb_wr(OFF_EN[0], 32'h0000_8000);
        pulse(0);
        pulse(10);
        chk(req_pending, 32'h0000_0401);
        chk(req_prio[10], 32'h0000_0007);
        chk(req_prio[0], 32'h0000_0003);
        chk({cpu_req, cpu_req_prio, cpu_req_src}, 32'h0000_01EA);
        ext_prio[0] <= 3'h0;
        repeat (2) @(posedge clk_sys);
        chk(req_pending, 32'h0000_0400);
        ext_prio[0] <= 3'h3;
        ack_lat <= 4'h3;
        ack_en <= 1'b1;
        for (int n = 0; n < 60 && req_pending !== '0; n++) @(posedge clk_sys);
        ack_en <= 1'b0;
        chk(req_pending, 32'h0000_0000);
        if (req_pending !== '0) print_verdict;
        ahb_rd(OFF_FLAG_STATUS, rd);
        chk(rd, 32'h0000_0000);
    endtask

    task t_irq;
        ahb_wr(OFF_FLAG_MASK, 32'h0002_0000);
        pulse(17);
        chk(irq_out, 1'b1);
        ahb_wr(OFF_FLAG_MASK, 32'h0000_0000);
        repeat (2) @(posedge clk_sys);
        chk(irq_out, 1'b0);
        ahb_wr(OFF_FLAG_MASK, 32'h0002_0000);
        repeat (2) @(posedge clk_sys);
        chk(irq_out, 1'b1);
        ahb_rd(OFF_FLAG_STATUS, rd);
        chk(rd, 32'h0002_0000);
        @(posedge clk_sys);
        chk(irq_out, 1'b0);
    endtask

    initial begin
        repeat (4) @(posedge clk_sys);
        srst <= 1'b0;
        @(posedge clk_sys);
        t_regs;
        t_forward;
        t_irq;
        print_verdict;
    end
endmodule
